// ### hdl/ivmap_pkg.sv
// Constants for the interrupt vector map
//==============================================================================
// Operation
// RULE_01: Undefined opcode raises vector 14, which has no level register.
// RULE_02: A/D converter request becomes vector 34, level from slot eighteen.
// RULE_03: Reload timers 0, 1, 2 become vectors 35-37, slots nineteen to twenty-one.
// RULE_04: Delayed request becomes vector 63, level from slot forty-seven.
// RULE_05: Fetch address is table base plus 0x3FC minus four times vector.
// RULE_06: Vectors 66 to 255 serve trap instructions, no level register.
// RULE_07: Delayed control register at 0430h, request bit resets to zero.
// RULE_08: Every level register resets to all ones.
//==============================================================================
package ivmap_pkg;
    // Register addresses on the native write/read port
    localparam logic [11:0] ADDR_LEVEL_BASE = 12'h400;
    localparam logic [11:0] ADDR_DELAYED    = 12'h430;
    localparam int          LEVEL_SLOTS     = 48;
    localparam logic [4:0]  LEVEL_RESET     = 5'h1F;
    // A level of all ones means the source is masked
    localparam logic [4:0]  LEVEL_MASKED    = 5'h1F;
    // Exceptions and traps carry no programmable level
    localparam logic [4:0]  LEVEL_EXCEPTION = 5'h00;
    // Vector numbers and level slots
    localparam logic [7:0]  VEC_UNDEF       = 8'h0E;
    localparam logic [7:0]  VEC_ADC         = 8'h22;
    localparam logic [7:0]  VEC_TMR0        = 8'h23;
    localparam logic [7:0]  VEC_DELAYED     = 8'h3F;
    localparam logic [7:0]  VEC_TRAP_FIRST  = 8'h42;
    localparam logic [5:0]  SLOT_ADC        = 6'h12;
    localparam logic [5:0]  SLOT_TMR0       = 6'h13;
    localparam logic [5:0]  SLOT_DELAYED    = 6'h2F;
    localparam int          TIMER_CHANNELS  = 3;
    localparam int          LEVEL_SOURCES   = 5;
    // Top of the vector table, relative to the base
    localparam logic [31:0] TABLE_TOP       = 32'h0000_03FC;
endpackage

// ### hdl/ivmap_top.sv
// Interrupt cause to vector mapping and vector fetch address
module ivmap_top
    import ivmap_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        undef_op,
    input  wire logic        trap_valid,
    input  wire logic [7:0]  trap_num,
    input  wire logic        adc_req,
    input  wire logic [2:0]  tmr_req,
    input  wire logic [31:0] vector_table_base,
    input  wire logic        wr_en,
    input  wire logic [11:0] wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic [11:0] rd_addr,
    output logic       [7:0] rd_data,
    output logic             irq_valid,
    output logic       [7:0] irq_vector,
    output logic       [4:0] irq_level,
    output logic      [31:0] fetch_addr,
    output logic             trap_reject,
    output logic             delayed_req
);

    //==========================================================================
    // State
    //==========================================================================
    typedef struct packed {
        logic [LEVEL_SLOTS-1:0][4:0] level;
        logic                        dly;
        logic                        vld;
        logic [7:0]                  vec;
        logic [4:0]                  lvl;
        logic [31:0]                 fetch;
        logic                        trap_rej;
        logic [7:0]                  rd;
    } ivmap_state_type;

    ivmap_state_type state_reg;
    ivmap_state_type state_next;

    // Level-controlled sources, ordered by rising vector number
    logic [LEVEL_SOURCES-1:0]      src_req;
    logic [LEVEL_SOURCES-1:0][7:0] src_vec;
    logic [LEVEL_SOURCES-1:0][5:0] src_slot;

    // Fixed source table; plain assigns so every entry has one kind of driver
    assign src_req[0]  = adc_req;
    assign src_vec[0]  = VEC_ADC;       // RULE_02
    assign src_slot[0] = SLOT_ADC;      // RULE_02
    assign src_req[LEVEL_SOURCES-1]  = state_reg.dly;
    assign src_vec[LEVEL_SOURCES-1]  = VEC_DELAYED;   // RULE_04
    assign src_slot[LEVEL_SOURCES-1] = SLOT_DELAYED;  // RULE_04

    // One entry per reload timer channel
    for (genvar ch = 0; ch < TIMER_CHANNELS; ch++)
    begin : g_tmr
        assign src_req[ch+1]  = tmr_req[ch];
        assign src_vec[ch+1]  = VEC_TMR0 + 8'(ch);   // RULE_03
        assign src_slot[ch+1] = SLOT_TMR0 + 6'(ch);  // RULE_03
    end

    //==========================================================================
    // Next state
    //==========================================================================
    always_comb
    begin
        logic       found;
        logic [7:0] best_vec;
        logic [4:0] best_lvl;
        logic [4:0] cand;
        found     = 1'b0;
        best_vec  = VEC_DELAYED;
        best_lvl  = LEVEL_MASKED;
        cand      = LEVEL_MASKED;
        state_next = state_reg;
        state_next.trap_rej = 1'b0;

        // Software writes to level slots and the delayed control bit
        if (wr_en && wr_addr >= ADDR_LEVEL_BASE
            && wr_addr < ADDR_LEVEL_BASE + 12'(LEVEL_SLOTS))
        begin
            state_next.level[6'(wr_addr - ADDR_LEVEL_BASE)] = wr_data[4:0];
        end
        if (wr_en && wr_addr == ADDR_DELAYED)
        begin
            state_next.dly = wr_data[0];  // RULE_07
        end

        // Readback of the same registers; holes read as zero
        state_next.rd = 8'h00;
        if (rd_addr >= ADDR_LEVEL_BASE && rd_addr < ADDR_LEVEL_BASE + 12'(LEVEL_SLOTS))
        begin
            state_next.rd = {3'b000, state_reg.level[6'(rd_addr - ADDR_LEVEL_BASE)]};
        end
        else if (rd_addr == ADDR_DELAYED)
        begin
            state_next.rd = {7'b000_0000, state_reg.dly};
        end

        // Lowest level wins; strict compare keeps the lower vector on a tie
        for (int i = 0; i < LEVEL_SOURCES; i++)
        begin
            cand = state_reg.level[src_slot[i]];
            if (src_req[i] && cand != LEVEL_MASKED && (!found || cand < best_lvl))
            begin
                found    = 1'b1;
                best_vec = src_vec[i];
                best_lvl = cand;
            end
        end

        // Exception first, then trap, then level-controlled causes
        if (undef_op)
        begin
            state_next.vld = 1'b1;
            state_next.vec = VEC_UNDEF;        // RULE_01
            state_next.lvl = LEVEL_EXCEPTION;  // RULE_01
        end
        else if (trap_valid && trap_num >= VEC_TRAP_FIRST)
        begin
            state_next.vld = 1'b1;
            state_next.vec = trap_num;         // RULE_06
            state_next.lvl = LEVEL_EXCEPTION;  // RULE_06
        end
        else
        begin
            // Trap numbers below the trap range are refused, not remapped
            state_next.trap_rej = trap_valid;  // RULE_06
            state_next.vld = found;
            state_next.vec = best_vec;
            state_next.lvl = best_lvl;
        end

        // Vectors are stored downward from the top of the table
        state_next.fetch = vector_table_base + TABLE_TOP
                         - {22'h00_0000, state_next.vec, 2'b00};  // RULE_05
    end

    //==========================================================================
    // Registers
    //==========================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg       <= '0;
            state_reg.level <= {LEVEL_SLOTS{LEVEL_RESET}};  // RULE_08
            state_reg.dly   <= 1'b0;                        // RULE_07
            state_reg.vec   <= VEC_UNDEF;
            state_reg.lvl   <= LEVEL_MASKED;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rd_data     = state_reg.rd;
    assign irq_valid   = state_reg.vld;
    assign irq_vector  = state_reg.vec;
    assign irq_level   = state_reg.lvl;
    assign fetch_addr  = state_reg.fetch;
    assign trap_reject = state_reg.trap_rej;
    assign delayed_req = state_reg.dly;

    //==========================================================================
    // Assertions
    //==========================================================================
    logic [31:0] exp_fetch;
    assign exp_fetch = TABLE_TOP - {22'h00_0000, irq_vector, 2'b00};

    sequence s_adc_alone;
        adc_req && tmr_req == 3'b000 && !state_reg.dly && !undef_op && !trap_valid
        && state_reg.level[SLOT_ADC] != LEVEL_MASKED;
    endsequence

    sequence s_dly_write;
        wr_en && wr_addr == ADDR_DELAYED;
    endsequence

    AST_UNDEF: assert property (@(posedge clk) disable iff (!arst_n) // RULE_01
        undef_op |=> irq_valid && irq_vector == VEC_UNDEF && irq_level == LEVEL_EXCEPTION)
        else $error("undefined opcode did not give vector 14");

    AST_ADC: assert property (@(posedge clk) disable iff (!arst_n) // RULE_02
        s_adc_alone |=> irq_vector == VEC_ADC
                        && irq_level == $past(state_reg.level[SLOT_ADC]))
        else $error("A/D request not mapped to vector 34");

    AST_TMR: assert property (@(posedge clk) disable iff (!arst_n) // RULE_03
        !adc_req && $onehot(tmr_req) && !state_reg.dly && !undef_op && !trap_valid
        && state_reg.level[SLOT_TMR0 + 6'($clog2(tmr_req))] != LEVEL_MASKED
        |=> irq_valid && irq_vector == VEC_TMR0 + 8'($clog2($past(tmr_req))))
        else $error("timer request mapped to wrong vector");

    AST_DLY: assert property (@(posedge clk) disable iff (!arst_n) // RULE_04
        state_reg.dly && !adc_req && tmr_req == 3'b000 && !undef_op && !trap_valid
        && state_reg.level[SLOT_DELAYED] != LEVEL_MASKED
        |=> irq_valid && irq_vector == VEC_DELAYED)
        else $error("delayed request not mapped to vector 63");

    AST_FETCH: assert property (@(posedge clk) disable iff (!arst_n) // RULE_05
        ##1 irq_valid |-> fetch_addr == $past(vector_table_base) + exp_fetch)
        else $error("fetch address does not match vector");

    AST_TRAP: assert property (@(posedge clk) disable iff (!arst_n) // RULE_06
        trap_valid && !undef_op
        |=> trap_reject == ($past(trap_num) < VEC_TRAP_FIRST)
            && (trap_reject || (irq_valid && irq_vector == $past(trap_num)
                                && irq_level == LEVEL_EXCEPTION)))
        else $error("trap range handling wrong");

    AST_DLY_WR: assert property (@(posedge clk) disable iff (!arst_n) // RULE_07
        s_dly_write ##1 rd_addr == ADDR_DELAYED |=> rd_data == {7'b000_0000, $past(wr_data[0], 2)})
        else $error("delayed control bit readback wrong");

    AST_LVL_RST: assert property (@(posedge clk) disable iff (!arst_n) // RULE_08
        $past(arst_n) == 1'b0 |-> state_reg.level[SLOT_DELAYED] == LEVEL_RESET
                                 && !state_reg.dly && !irq_valid)
        else $error("level register not all ones after reset");

endmodule

// ### tb/ivmap_source_model.sv
// Peripheral request source model: reload timers and A/D converter
module ivmap_source_model
(
    input  wire logic       clk,
    input  wire logic       adc_on,
    input  wire logic [2:0] tmr_on,
    output logic            adc_req,
    output logic      [2:0] tmr_req
);
    timeunit 1ns;
    timeprecision 1ns;
    //==========================================================================
    // Level requests
    // Sources move through their own output flop on the rising edge; sampling
    // the falling-edge stimulus here would race the bench
    initial adc_req = 1'b0;
    initial tmr_req = 3'h0;
    always @(posedge clk)
    begin
        adc_req <= adc_on;
        tmr_req <= tmr_on;
    end
endmodule

// ### tb/interrupt_vector_map_test.sv
// Self-checking bench for the interrupt vector map
module interrupt_vector_map_test
    import ivmap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, arst_n, undef_op, trap_valid, wr_en, adc_on, adc_req;
    logic        irq_valid, trap_reject, delayed_req;
    logic [2:0]  tmr_on, tmr_req;
    logic [7:0]  trap_num, wr_data, rd_data, irq_vector, seed, lvl;
    logic [11:0] wr_addr, rd_addr;
    logic [31:0] base, fetch_addr;
    logic [4:0]  irq_level;
    int          err_count, samples_checked;
    logic [7:0]  traps [4];

    ivmap_top i_ivmap_top (.clk(clk), .arst_n(arst_n), .undef_op(undef_op),
        .trap_valid(trap_valid), .trap_num(trap_num), .adc_req(adc_req),
        .tmr_req(tmr_req), .vector_table_base(base), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .irq_level(irq_level), .fetch_addr(fetch_addr),
        .trap_reject(trap_reject), .delayed_req(delayed_req));
    ivmap_source_model i_ivmap_source_model (.clk(clk), .adc_on(adc_on),
        .tmr_on(tmr_on), .adc_req(adc_req), .tmr_req(tmr_req));

    //==========================================================================
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Vector table grows downward from the top word
    function automatic logic [31:0] exp_fetch(input logic [31:0] b, input logic [7:0] v);
        return b + TABLE_TOP - {22'h0, v, 2'b00};
    endfunction
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One idle cycle after each write, so back-to-back calls never retoggle the strobe
    task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
        wr_addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        @(negedge clk);
    endtask
    task automatic read_check(input logic [11:0] a, input logic [7:0] e);
        rd_addr = a;
        @(negedge clk);
        check_val({24'h0, rd_data}, {24'h0, e});
    endtask
    // Two falling edges cover the source model's own register stage
    task automatic check_irq(input logic [7:0] v, input logic [4:0] l);
        repeat (2) @(negedge clk);
        check_val({31'h0, irq_valid}, 32'h1);
        check_val({24'h0, irq_vector}, {24'h0, v});
        check_val({27'h0, irq_level}, {27'h0, l});
        check_val(fetch_addr, exp_fetch(base, v));
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    //==========================================================================
    // Clock and watchdog; a hang is far beyond the roughly 80 cycles needed
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #40000;
        err_count++;
        finish_test();
    end

    //==========================================================================
    // Main sequence
    initial
    begin
        {arst_n, undef_op, trap_valid, wr_en, adc_on, tmr_on} = '0;
        {trap_num, wr_data, wr_addr, rd_addr} = '0;
        seed = 8'h50;
        base = 32'h000F_FC00;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        for (int n = 0; n < LEVEL_SLOTS; n += 5)
            read_check(ADDR_LEVEL_BASE + 12'(n), {3'h0, LEVEL_RESET});
        read_check(ADDR_DELAYED, 8'h00);
        reg_write(12'h431, 8'hFF);
        read_check(12'h431, 8'h00);
        $display("test reset done");
        seed = lfsr(seed);
        base = {16'h0010, seed, 8'h00};
        lvl = {4'h0, seed[3:0]};
        reg_write(ADDR_LEVEL_BASE + 12'(SLOT_ADC), lvl);
        read_check(ADDR_LEVEL_BASE + 12'(SLOT_ADC), lvl);
        adc_on = 1'b1;
        undef_op = 1'b1;
        check_irq(VEC_UNDEF, LEVEL_EXCEPTION);
        undef_op = 1'b0;
        check_irq(VEC_ADC, lvl[4:0]);
        adc_on = 1'b0;
        $display("test undef and adc done");
        for (int ch = 0; ch < TIMER_CHANNELS; ch++)
        begin
            reg_write(ADDR_LEVEL_BASE + 12'(SLOT_TMR0) + 12'(ch), 8'(ch + 1));
            tmr_on = 3'(1 << ch);
            check_irq(VEC_TMR0 + 8'(ch), 5'(ch + 1));
        end
        // Two level sources at once: lower level wins, a tie keeps the lower vector
        adc_on = 1'b1;
        check_irq((lvl[4:0] <= 5'h03) ? VEC_ADC : VEC_TMR0 + 8'h02,
                  (lvl[4:0] <= 5'h03) ? lvl[4:0] : 5'h03);
        tmr_on = 3'h0;
        // A level of all ones masks the source
        reg_write(ADDR_LEVEL_BASE + 12'(SLOT_ADC), {3'h0, LEVEL_MASKED});
        repeat (2) @(negedge clk);
        check_val({31'h0, irq_valid}, 32'h0);
        adc_on = 1'b0;
        $display("test timers done");
        traps[0] = VEC_TRAP_FIRST;
        traps[1] = 8'hFF;
        for (int i = 2; i < 4; i++)
        begin
            seed = lfsr(seed);
            traps[i] = (seed < VEC_TRAP_FIRST) ? seed + VEC_TRAP_FIRST : seed;
        end
        trap_valid = 1'b1;
        foreach (traps[i])
        begin
            trap_num = traps[i];
            check_irq(trap_num, LEVEL_EXCEPTION);
        end
        trap_num = VEC_TRAP_FIRST - 8'h01;
        repeat (2) @(negedge clk);
        check_val({31'h0, trap_reject}, 32'h1);
        check_val({31'h0, irq_valid}, 32'h0);
        trap_valid = 1'b0;
        $display("test traps done");
        reg_write(ADDR_LEVEL_BASE + 12'(SLOT_DELAYED), 8'h04);
        rd_addr = ADDR_DELAYED;
        reg_write(ADDR_DELAYED, 8'h01);
        check_val({31'h0, delayed_req}, 32'h1);
        read_check(ADDR_DELAYED, 8'h01);
        check_irq(VEC_DELAYED, 5'h04);
        reg_write(ADDR_DELAYED, 8'h00);
        repeat (2) @(negedge clk);
        check_val({31'h0, irq_valid}, 32'h0);
        $display("test delayed done");
        finish_test();
    end
endmodule
